// [hw/dpc_map.svh]
// Register indices, field positions and reset values of the pattern checker.
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH
`define DPC_IDX_CTRL 10'h14B
`define DPC_IDX_CNT_I 10'h14C
`define DPC_IDX_CNT_Q 10'h14D
`define DPC_IDX_CHSEL 10'h14E
`define DPC_IDX_IRQ_STS 10'h160
`define DPC_IDX_IRQ_CLR 10'h161
`define DPC_IDX_IRQ_EN 10'h162
`define DPC_BIT_EN 0
`define DPC_BIT_RST 1
`define DPC_BIT_MODE 2
`define DPC_BIT_INV_I 3
`define DPC_BIT_INV_Q 4
`define DPC_BIT_GOOD_I 6
`define DPC_BIT_GOOD_Q 7
`define DPC_IRQ_ERR_I 0
`define DPC_IRQ_ERR_Q 1
`define DPC_IRQ_SAT 2
`define DPC_RST_CTRL 5'h10
`define DPC_RST_CHSEL 3'h7
`define DPC_RST_GOOD 1'h0
`define DPC_SEL_ALL 3'h6
`define DPC_FILL7 4'h7
`define DPC_FILL15 4'hF
`define DPC_CNT_MAX 8'hFF
`endif

// [hw/dpc_pkg.sv]
// Types and shared functions of the datapath pattern checker.
`default_nettype none
package dpc_pkg;
   typedef struct packed {
      logic [14:0] shift;
      logic [3:0] fill;
      logic good;
      logic [7:0] count;
      logic err;
   } dpc_lane_st_t;

   typedef struct packed {
      logic [4:0] ctrl;
      logic [2:0] chsel;
      logic [2:0] sts;
      logic [2:0] ien;
      logic [31:0] prdata;
      logic slverr;
   } dpc_top_st_t;

   // Expected next bit from the received history; bit 0 is the newest.
   function automatic logic pattern_check_control_status_expect(input logic [14:0] s, input logic mode);
      pattern_check_control_status_expect = mode ? (s[14] ^ s[13]) : (s[6] ^ s[5]);
   endfunction
endpackage
`default_nettype wire

// [hw/dpc_lane_if.sv]
// Configuration and results between the top and one lane checker.
`timescale 1ns/1ps
`default_nettype none
interface dpc_lane_if;
   logic enable;
   logic mode;
   logic invert;
   logic chk_reset;
   logic good;
   logic [7:0] count;
   logic err;
   modport chk (input enable, mode, invert, chk_reset, output good, count, err);
   modport ctl (output enable, mode, invert, chk_reset, input good, count, err);
endinterface
`default_nettype wire

// [hw/dpc_lane.sv]
// One self-synchronising pattern checker lane with flag and error counter.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.svh"
module dpc_lane (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic smp_valid,
   input wire logic smp_bit,
   dpc_lane_if.chk lane
);
   import dpc_pkg::*;

   dpc_lane_st_t q, d;
   logic rx;
   logic filled;

   // ****************************************
   // Checker
   // ****************************************
   // The reference is seeded from the line itself, so no alignment is needed.
   assign rx = smp_bit ^ lane.invert;
   assign filled = q.fill >= (lane.mode ? `DPC_FILL15 : `DPC_FILL7);

   always_comb begin
      d = q;
      d.err = 1'b0;
      if (lane.chk_reset) begin
         d.count = 8'h00;
         d.good = 1'b1;
         d.fill = 4'h0;
      end else if (!lane.enable) begin
         d.fill = 4'h0;
      end else if (smp_valid) begin
         d.shift = {q.shift[13:0], rx};
         if (!filled) begin
            d.fill = q.fill + 4'h1;
         end else if (rx != pattern_check_control_status_expect(q.shift, lane.mode)) begin
            d.err = 1'b1;
            d.good = 1'b0;
            if (q.count != `DPC_CNT_MAX) begin
               d.count = q.count + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{shift: 15'h0000, fill: 4'h0, good: `DPC_RST_GOOD, count: 8'h00, err: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign lane.good = q.good;
   assign lane.count = q.count;
   assign lane.err = q.err;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic chk;
   assign chk = lane.enable && !lane.chk_reset && smp_valid && filled;

   cnt_clear_a: assert property (lane.chk_reset |=> q.count == 8'h00)
      else $error("counter not cleared by checker reset");
   good_set_a: assert property (lane.chk_reset |=> q.good)
      else $error("flag not restored by checker reset");
   good_drop_a: assert property (chk && rx != pattern_check_control_status_expect(q.shift, lane.mode) |=> !q.good)
      else $error("flag did not drop on mismatch");
   good_hold_a: assert property (!q.good && !lane.chk_reset |=> !q.good)
      else $error("flag left low state without reset");
   count_inc_a: assert property (chk && rx != pattern_check_control_status_expect(q.shift, lane.mode)
      && q.count != `DPC_CNT_MAX |=> q.count == $past(q.count) + 8'h01)
      else $error("error count did not advance");
   poly7_a: assert property (chk && !lane.mode
      && (smp_bit ^ lane.invert) == (q.shift[6] ^ q.shift[5]) |=> !q.err)
      else $error("seven-bit sequence flagged wrongly");
   poly15_a: assert property (chk && lane.mode
      && (smp_bit ^ lane.invert) == (q.shift[14] ^ q.shift[13]) |=> !q.err)
      else $error("fifteen-bit sequence flagged wrongly");
   inv_a: assert property (chk && lane.invert
      && smp_bit == pattern_check_control_status_expect(q.shift, lane.mode) |=> q.err)
      else $error("inverted expectation not applied");
endmodule
`default_nettype wire

// [hw/dpc_top.sv]
// Datapath pattern checker with APB registers, readback select and interrupt.
//
// Summary of operation
// - Reference follows x^7+x^6+1 when polynomial_select is 0, x^15+x^14+1 when 1.
// - Separate match flags for the Q path (converter 1) and I path (converter 0).
// - A match flag resets to 0; from checker_counter_reset on it reads 1 while received samples follow the expected sequence.
// - A mismatch drops the flag to 0 until checker_counter_reset returns it to 1.
// - Read-only 8-bit error counts for the I path and the Q path.
// - A 3-bit select chooses the channel shown in both flags and both counts.
// - Select values 0, 1, 2 show channels 0, 1, 2 of converter 0.
// - Select values 3, 4, 5 show channels 0, 1, 2 of converter 1.
// - Select value 6 shows the OR of all flags and the sum of all counts, saturated at 255.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.svh"
module dpc_top #(
   parameter int NUM_CH = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic [NUM_CH-1:0] smp_valid,
   input wire logic [NUM_CH-1:0] smp_i,
   input wire logic [NUM_CH-1:0] smp_q
);
   import dpc_pkg::*;

   dpc_top_st_t q, d;
   logic [NUM_CH-1:0] good_i, good_q, err_i, err_q;
   logic [NUM_CH-1:0][7:0] cnt_i, cnt_q;
   logic [9:0] idx;
   logic setup, wr_acc, mapped;
   logic sel_good_i, sel_good_q;
   logic [7:0] sel_cnt_i, sel_cnt_q;
   logic [2:0] sts_set;
   logic any_sat;

   // ****************************************
   // Lanes
   // ****************************************
   // Each channel carries one I lane and one Q lane with their own invert bit; enable, mode and reset are shared.
   for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      dpc_lane_if li();
      dpc_lane_if lq();
      assign li.enable = q.ctrl[`DPC_BIT_EN];
      assign li.mode = q.ctrl[`DPC_BIT_MODE];
      assign li.chk_reset = q.ctrl[`DPC_BIT_RST];
      assign li.invert = q.ctrl[`DPC_BIT_INV_I];
      assign lq.enable = q.ctrl[`DPC_BIT_EN];
      assign lq.mode = q.ctrl[`DPC_BIT_MODE];
      assign lq.chk_reset = q.ctrl[`DPC_BIT_RST];
      assign lq.invert = q.ctrl[`DPC_BIT_INV_Q];
      dpc_lane u_i (
         .pclk(pclk),
         .presetn(presetn),
         .smp_valid(smp_valid[g]),
         .smp_bit(smp_i[g]),
         .lane(li)
      );
      dpc_lane u_q (
         .pclk(pclk),
         .presetn(presetn),
         .smp_valid(smp_valid[g]),
         .smp_bit(smp_q[g]),
         .lane(lq)
      );
      assign good_i[g] = li.good;
      assign good_q[g] = lq.good;
      assign cnt_i[g] = li.count;
      assign cnt_q[g] = lq.count;
      assign err_i[g] = li.err;
      assign err_q[g] = lq.err;
   end

   // ****************************************
   // Readback select
   // ****************************************
   function automatic logic pick_flag(input logic [NUM_CH-1:0] f, input logic [2:0] sel);
      if (sel == `DPC_SEL_ALL) begin
         pick_flag = |f;
      end else if (32'(sel) < NUM_CH) begin
         pick_flag = f[sel];
      end else begin
         pick_flag = 1'b0;
      end
   endfunction

   // The sum saturates so that a busy link never wraps to a small count.
   function automatic logic [7:0] pick_count(input logic [NUM_CH-1:0][7:0] c,
                                             input logic [2:0] sel);
      logic [15:0] sum;
      sum = 16'h0000;
      pick_count = 8'h00;
      if (sel == `DPC_SEL_ALL) begin
         for (int k = 0; k < NUM_CH; k++) begin
            sum = sum + {8'h00, c[k]};
         end
         pick_count = (sum > 16'h00FF) ? `DPC_CNT_MAX : sum[7:0];
      end else if (32'(sel) < NUM_CH) begin
         pick_count = c[sel];
      end
   endfunction

   assign sel_good_i = pick_flag(good_i, q.chsel);
   assign sel_good_q = pick_flag(good_q, q.chsel);
   assign sel_cnt_i = pick_count(cnt_i, q.chsel);
   assign sel_cnt_q = pick_count(cnt_q, q.chsel);

   // ****************************************
   // Interrupt events
   // ****************************************
   always_comb begin
      any_sat = 1'b0;
      for (int k = 0; k < NUM_CH; k++) begin
         any_sat = any_sat | (cnt_i[k] == `DPC_CNT_MAX) | (cnt_q[k] == `DPC_CNT_MAX);
      end
   end

   assign sts_set = {any_sat, |err_q, |err_i};
   assign irq = |(q.sts & q.ien);

   // ****************************************
   // APB slave
   // ****************************************
   assign idx = paddr[11:2];
   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite && mapped;
   assign mapped = idx == `DPC_IDX_CTRL || idx == `DPC_IDX_CNT_I || idx == `DPC_IDX_CNT_Q
      || idx == `DPC_IDX_CHSEL || idx == `DPC_IDX_IRQ_STS || idx == `DPC_IDX_IRQ_CLR
      || idx == `DPC_IDX_IRQ_EN;
   assign pready = 1'b1;
   assign pslverr = q.slverr && psel && penable;
   assign prdata = q.prdata;

   always_comb begin
      d = q;
      d.sts = q.sts | sts_set;
      if (setup) begin
         d.slverr = !mapped;
         d.prdata = 32'h0000_0000;
         if (!pwrite) begin
            case (idx)
               `DPC_IDX_CTRL: d.prdata[7:0] = {sel_good_q, sel_good_i, 1'b0, q.ctrl};
               `DPC_IDX_CNT_I: d.prdata[7:0] = sel_cnt_i;
               `DPC_IDX_CNT_Q: d.prdata[7:0] = sel_cnt_q;
               `DPC_IDX_CHSEL: d.prdata[2:0] = q.chsel;
               `DPC_IDX_IRQ_STS: d.prdata[2:0] = q.sts;
               `DPC_IDX_IRQ_EN: d.prdata[2:0] = q.ien;
               default: d.prdata = 32'h0000_0000;
            endcase
         end
      end
      if (wr_acc && pstrb[0]) begin
         case (idx)
            `DPC_IDX_CTRL: d.ctrl = pwdata[4:0];
            `DPC_IDX_CHSEL: d.chsel = pwdata[2:0];
            // A new event in the same cycle survives the clear.
            `DPC_IDX_IRQ_CLR: d.sts = (q.sts & ~pwdata[2:0]) | sts_set;
            `DPC_IDX_IRQ_EN: d.ien = pwdata[2:0];
            default: d.ctrl = q.ctrl;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '{ctrl: `DPC_RST_CTRL, chsel: `DPC_RST_CHSEL, sts: 3'h0, ien: 3'h0,
                prdata: 32'h0000_0000, slverr: 1'b0};
      end else begin
         q <= d;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence rd_setup(logic [9:0] a);
      psel && !penable && !pwrite && idx == a;
   endsequence

   sequence rd_access;
      psel && penable;
   endsequence

   sequence wr_access(logic [9:0] a);
      psel && penable && pwrite && pstrb[0] && idx == a;
   endsequence

   // ****************************************
   // Check helpers
   // ****************************************
   // The sums are kept wide, so that saturation of the readback is checked on its own.
   logic [10:0] sum_i, sum_q;
   logic or_i, or_q;

   always_comb begin
      sum_i = 11'h000;
      sum_q = 11'h000;
      or_i = 1'b0;
      or_q = 1'b0;
      for (int k = 0; k < NUM_CH; k++) begin
         sum_i = sum_i + 11'(cnt_i[k]);
         sum_q = sum_q + 11'(cnt_q[k]);
         or_i = or_i | good_i[k];
         or_q = or_q | good_q[k];
      end
   end

   // Readback follows the select that stands in the setup cycle.
   rb_chan_i_a: assert property (rd_setup(`DPC_IDX_CNT_I) ##0 q.chsel < 3'h6
      |=> rd_access |-> prdata[7:0] == $past(cnt_i[q.chsel]))
      else $error("I count readback does not follow the select");
   rb_chan_q_a: assert property (rd_setup(`DPC_IDX_CNT_Q) ##0 q.chsel < 3'h6
      |=> rd_access |-> prdata[7:0] == $past(cnt_q[q.chsel]))
      else $error("Q count readback does not follow the select");
   rb_flag_i_a: assert property (rd_setup(`DPC_IDX_CTRL) ##0 q.chsel < 3'h6
      |=> prdata[`DPC_BIT_GOOD_I] == $past(good_i[q.chsel]))
      else $error("I flag readback does not follow the select");
   rb_flag_q_a: assert property (rd_setup(`DPC_IDX_CTRL) ##0 q.chsel < 3'h6
      |=> prdata[`DPC_BIT_GOOD_Q] == $past(good_q[q.chsel]))
      else $error("Q flag readback does not follow the select");
   rb_or_a: assert property (rd_setup(`DPC_IDX_CTRL) ##0 q.chsel == `DPC_SEL_ALL
      |=> prdata[`DPC_BIT_GOOD_I] == $past(or_i) && prdata[`DPC_BIT_GOOD_Q] == $past(or_q))
      else $error("combined flag readback is not the OR");
   rb_sum_a: assert property (rd_setup(`DPC_IDX_CNT_I) ##0 q.chsel == `DPC_SEL_ALL
      |=> prdata[7:0] == ($past(sum_i) > 11'h0FF ? `DPC_CNT_MAX : $past(sum_i[7:0])))
      else $error("combined count readback is not the sum");
   rb_sum_q_a: assert property (rd_setup(`DPC_IDX_CNT_Q) ##0 q.chsel == `DPC_SEL_ALL
      |=> prdata[7:0] == ($past(sum_q) > 11'h0FF ? `DPC_CNT_MAX : $past(sum_q[7:0])))
      else $error("combined Q count readback is not the sum");
   rb_none_a: assert property (rd_setup(`DPC_IDX_CNT_Q) ##0 q.chsel == 3'h7
      |=> prdata == 32'h0000_0000)
      else $error("unused select does not read zero");
   rb_spare_a: assert property (rd_setup(`DPC_IDX_CTRL)
      |=> prdata[5] == 1'b0 && prdata[31:8] == 24'h00_0000)
      else $error("spare control bits do not read zero");
   // Read data is latched in the setup cycle, so it must not move until the next setup.
   rd_stand_a: assert property (rd_access |=> $stable(prdata))
      else $error("read data changed after the access");

   wr_ctrl_a: assert property (wr_access(`DPC_IDX_CTRL) |=> q.ctrl == $past(pwdata[4:0]))
      else $error("control write did not land");
   wr_chsel_a: assert property (wr_access(`DPC_IDX_CHSEL)
      |=> q.chsel == $past(pwdata[2:0]))
      else $error("select write did not land");
   wr_ien_a: assert property (wr_access(`DPC_IDX_IRQ_EN) |=> q.ien == $past(pwdata[2:0]))
      else $error("interrupt enable write did not land");
   wr_strb_a: assert property (psel && penable && pwrite && !pstrb[0]
      |=> $stable(q.ctrl) && $stable(q.chsel) && $stable(q.ien))
      else $error("write without byte strobe took effect");
   slverr_a: assert property (rd_access |-> pslverr == !mapped)
      else $error("error response does not match the decode");

   sts_keep_a: assert property (q.sts[`DPC_IRQ_ERR_I] && !(wr_acc && idx == `DPC_IDX_IRQ_CLR)
      |=> q.sts[`DPC_IRQ_ERR_I])
      else $error("status bit lost without clear");
   sts_keep_q_a: assert property (q.sts[`DPC_IRQ_ERR_Q] && !(wr_acc && idx == `DPC_IDX_IRQ_CLR)
      |=> q.sts[`DPC_IRQ_ERR_Q])
      else $error("Q status bit lost without clear");
   sts_set_a: assert property (|err_i |=> q.sts[`DPC_IRQ_ERR_I]
      && (irq || !q.ien[`DPC_IRQ_ERR_I]))
      else $error("lane error did not raise status");
   sts_clr_a: assert property (wr_access(`DPC_IDX_IRQ_CLR)
      ##0 pwdata[`DPC_IRQ_ERR_Q] && !(|err_q) |=> !q.sts[`DPC_IRQ_ERR_Q])
      else $error("status bit not cleared by a write of one");
   // A clear that meets a new event must lose, or an error could go unseen.
   sts_win_a: assert property (wr_access(`DPC_IDX_IRQ_CLR) ##0 (|err_i)
      |=> q.sts[`DPC_IRQ_ERR_I])
      else $error("new event lost to a same-cycle clear");
   sat_sts_a: assert property (any_sat |=> q.sts[`DPC_IRQ_SAT])
      else $error("saturated count did not raise status");
   sat_clr_a: assert property (wr_access(`DPC_IDX_IRQ_CLR)
      ##0 pwdata[`DPC_IRQ_SAT] && !any_sat |=> !q.sts[`DPC_IRQ_SAT])
      else $error("saturation status not cleared by a write of one");
   irq_off_a: assert property (q.ien == 3'h0 |-> !irq)
      else $error("interrupt raised with every source disabled");
   irq_i_a: assert property (q.sts[`DPC_IRQ_ERR_I] && q.ien[`DPC_IRQ_ERR_I] |-> irq)
      else $error("enabled I status did not raise the interrupt");
   irq_q_a: assert property (q.sts[`DPC_IRQ_ERR_Q] && q.ien[`DPC_IRQ_ERR_Q] |-> irq)
      else $error("enabled Q status did not raise the interrupt");
   irq_on_a: assert property (q.sts[`DPC_IRQ_SAT] && q.ien[`DPC_IRQ_SAT] |-> irq)
      else $error("enabled saturation status did not raise the interrupt");

   // Every lane clears at the edge after the reset bit is seen, whatever the select.
   rst_clear_a: assert property (q.ctrl[`DPC_BIT_RST]
      |=> sum_i == 11'h000 && sum_q == 11'h000)
      else $error("counts not cleared under checker reset");
endmodule
`default_nettype wire

// [bench/dpc_tx_model.sv]
// Link transmitter model sending the test pattern on six I and six Q lanes.
`timescale 1ns/1ps
`default_nettype none
module dpc_tx_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic mode,
   input wire logic inv_i,
   input wire logic inv_q,
   input wire logic [5:0] go,
   input wire logic [5:0] flip_i,
   input wire logic [5:0] flip_q,
   output logic [5:0] smp_valid,
   output logic [5:0] smp_i,
   output logic [5:0] smp_q
);
   // ****************
   // Pattern source
   // ****************
   logic [14:0] hist_q [12];

   function automatic logic nxt(input logic [14:0] h, input logic m);
      return m ? (h[14] ^ h[13]) : (h[6] ^ h[5]);
   endfunction

   // A flip corrupts the sent bit only; the true history keeps running.
   // Idle lanes show the inverse of their last bit, so stale data never matches.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < 12; k++)
            hist_q[k] <= 15'h1 + 15'(k * 37);
         smp_valid <= '0;
         smp_i <= '0;
         smp_q <= '0;
      end else begin
         for (int c = 0; c < 6; c++) begin
            smp_valid[c] <= go[c];
            if (go[c]) begin
               hist_q[c] <= {hist_q[c][13:0], nxt(hist_q[c], mode)};
               hist_q[c+6] <= {hist_q[c+6][13:0], nxt(hist_q[c+6], mode)};
               smp_i[c] <= nxt(hist_q[c], mode) ^ inv_i ^ flip_i[c];
               smp_q[c] <= nxt(hist_q[c+6], mode) ^ inv_q ^ flip_q[c];
            end else begin
               smp_i[c] <= ~smp_i[c];
               smp_q[c] <= ~smp_q[c];
            end
         end
      end
   end
endmodule
`default_nettype wire

// [bench/dpc_top_tb.sv]
// Self-checking bench of the datapath pattern checker.
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.svh"
module dpc_top_tb;
   // ****************
   // Stimulus and expectation
   // ****************
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, se;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, rv;
   logic [3:0] pstrb;
   logic [5:0] go, fi, fq, sv, si, sq;
   logic [4:0] ctl, v;
   logic [31:0] seed = 32'hA20150C3;
   int num_errors = 0;
   int n_checks = 0;
   int cnt[2][6];
   logic good[2][6];

   dpc_top dpc_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .smp_valid(sv), .smp_i(si), .smp_q(sq));
   dpc_tx_model dpc_tx_model_i (.pclk(pclk), .presetn(presetn), .mode(ctl[2]),
      .inv_i(ctl[3]), .inv_q(ctl[4]), .go(go), .flip_i(fi), .flip_q(fq), .smp_valid(sv),
      .smp_i(si), .smp_q(sq));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Select 6 sums every channel, select 7 shows nothing.
   function automatic logic [7:0] ecnt(input int s, input int q);
      int t;
      t = 0;
      for (int c = 0; c < 6; c++)
         if (s == 6 || s == c) t += cnt[q][c];
      return (t > 255) ? 8'hFF : 8'(t);
   endfunction

   function automatic logic eg(input int s, input int q);
      logic r;
      r = 1'b0;
      for (int c = 0; c < 6; c++)
         if (s == 6 || s == c) r |= good[q][c];
      return r;
   endfunction

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d,
      input logic [3:0] s);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {a, 2'b00};
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         num_errors++;
         complete_run();
      end
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input logic [9:0] a, input logic [31:0] exp);
      apb(1'b0, a, 8'h00, 4'hF);
      chk(rd, exp);
   endtask

   // A checker reset returns every flag to 1 and every count to 0.
   task automatic setc(input logic [4:0] x);
      ctl <= x;
      apb(1'b1, `DPC_IDX_CTRL, {3'b000, x}, 4'hF);
      if (x[1])
         foreach (cnt[q, c]) begin
            cnt[q][c] = 0;
            good[q][c] = 1'b1;
         end
   endtask

   task automatic check_all();
      for (int s = 0; s < 8; s++) begin
         apb(1'b1, `DPC_IDX_CHSEL, 8'(s), 4'hF);
         rdc(`DPC_IDX_CTRL, {24'h0, eg(s, 1), eg(s, 0), 1'b0, ctl});
         rdc(`DPC_IDX_CNT_I, {24'h0, ecnt(s, 0)});
         rdc(`DPC_IDX_CNT_Q, {24'h0, ecnt(s, 1)});
      end
   endtask

   // One flipped bit sits in the checker history for two more taps, so it costs 3 errors.
   task automatic inject(input int c, input int q, input int n);
      repeat (n) begin
         @(posedge pclk);
         if (q == 1)
            fq[c] <= 1'b1;
         else
            fi[c] <= 1'b1;
         @(posedge pclk);
         fi <= '0;
         fq <= '0;
         repeat (20) @(posedge pclk);
         cnt[q][c] += 3;
         good[q][c] = 1'b0;
      end
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      ctl = 5'h10;
      go = '0;
      fi = '0;
      fq = '0;
      foreach (good[q, c])
         good[q][c] = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdc(`DPC_IDX_CTRL, 32'h10);
      rdc(`DPC_IDX_CHSEL, 32'h7);
      rdc(`DPC_IDX_CNT_Q, 32'h0);
      rdc(`DPC_IDX_IRQ_STS, 32'h0);
      apb(1'b0, 10'h150, 8'h00, 4'hF);
      chk({31'h0, se}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, `DPC_IDX_CHSEL, 8'h02, 4'h0);
      rdc(`DPC_IDX_CHSEL, 32'h7);
      for (int m = 0; m < 2; m++) begin
         rv = rnd();
         v = {rv[1:0], m[0], 2'b00};
         setc(v);
         setc(v | 5'h3);
         setc(v | 5'h1);
         repeat (80) begin
            @(posedge pclk);
            go <= 6'(rnd());
         end
         @(posedge pclk);
         go <= 6'h3F;
         check_all();
         apb(1'b1, `DPC_IDX_IRQ_EN, 8'h00, 4'hF);
         apb(1'b1, `DPC_IDX_IRQ_CLR, 8'h07, 4'hF);
         inject(int'(rnd() % 6), 0, 1 + m);
         inject(int'(rnd() % 6), 1, 2);
         chk({31'h0, irq}, 32'h0);
         rdc(`DPC_IDX_IRQ_STS, 32'h3);
         apb(1'b1, `DPC_IDX_IRQ_EN, 8'h03, 4'hF);
         @(posedge pclk);
         chk({31'h0, irq}, 32'h1);
         check_all();
         apb(1'b1, `DPC_IDX_IRQ_CLR, 8'h03, 4'hF);
         @(posedge pclk);
         chk({31'h0, irq}, 32'h0);
         setc(v | 5'h3);
         setc(v | 5'h1);
         check_all();
      end
      apb(1'b1, `DPC_IDX_IRQ_CLR, 8'h07, 4'hF);
      apb(1'b1, `DPC_IDX_IRQ_EN, 8'h04, 4'hF);
      inject(0, 0, 86);
      rdc(`DPC_IDX_IRQ_STS, 32'h5);
      chk({31'h0, irq}, 32'h1);
      check_all();
      complete_run();
   end

   initial begin
      repeat (100000) @(posedge pclk);
      num_errors++;
      complete_run();
   end
endmodule
`default_nettype wire
